// *** hw/itc_defines.svh ***
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH

// Control word field positions.
`define ITC_CTRL_ON_BIT        15
`define ITC_CTRL_IDLE_STOP_BIT 13
`define ITC_CTRL_GATE_BIT      6
`define ITC_CTRL_PS_MSB        5
`define ITC_CTRL_PS_LSB        4
`define ITC_CTRL_SYNC_BIT      2
`define ITC_CTRL_CS_BIT        1

// Reset values.
`define ITC_COUNT_RST          16'h0000
`define ITC_PS_CNT_RST         8'h00

// Prescaler terminal counts for ratios 1, 8, 64 and 256.
`define ITC_PS_TERM_1          8'h00
`define ITC_PS_TERM_8          8'h07
`define ITC_PS_TERM_64         8'h3F
`define ITC_PS_TERM_256        8'hFF

// Pin input order in the synchroniser bank.
`define ITC_PIN_EXT            0
`define ITC_PIN_GATE           1
`define ITC_PIN_COUNT          2

`endif

// *** hw/itc_pkg.sv ***
package itc_pkg;

  typedef enum logic [2:0] {
    ITC_MODE_TIMER = 3'b001,
    ITC_MODE_SYNC  = 3'b010,
    ITC_MODE_ASYNC = 3'b100
  } itc_mode_e;

  typedef struct packed {
    logic       enable;
    logic       idle_stop;
    logic       gate_en;
    logic [1:0] prescale;
    itc_mode_e  mode;
  } itc_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } itc_cnt_wr_s;

endpackage

// *** hw/itc_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "itc_defines.svh"

module itc_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] sel,
  output logic            tick_out
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic [WIDTH-1:0] term;
  logic             tick_r;
  logic             tick_nxt;

  always_comb begin
    case (sel)
      2'h0:    term = WIDTH'(`ITC_PS_TERM_1);
      2'h1:    term = WIDTH'(`ITC_PS_TERM_8);
      2'h2:    term = WIDTH'(`ITC_PS_TERM_64);
      default: term = WIDTH'(`ITC_PS_TERM_256);
    endcase
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = WIDTH'(`ITC_PS_CNT_RST);
    end else if (tick_in) begin
      if (cnt_r >= term) begin
        cnt_nxt  = WIDTH'(`ITC_PS_CNT_RST);
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r  <= WIDTH'(`ITC_PS_CNT_RST);
      tick_r <= 1'b0;
    end else if (ce) begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule

`default_nettype wire

// *** hw/itc_timer.sv ***
// Summary of operation
// - Timer mode counts cycles, wraps at period.
// - Timer mode halts in idle when idle-stop set.
// - Synchronous counter counts synchronised external rising edges.
// - Synchronous counter obeys the same idle-stop rule.
// - Asynchronous counter counts external rising edges, wraps at period.
// - Asynchronous counter halts in idle when idle-stop set.
// - Interrupt on period match or gate falling edge.
// - Gating in timer mode, prescaler, running in idle, and in sleep for the asynchronous counter.
// - Usable as clock counter or free-running timer.
`timescale 1ns/1ps
`default_nettype none
`include "itc_defines.svh"

module itc_timer #(
  parameter int PS_WIDTH = 8
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic [15:0]         timer_control_reg,
  input  wire logic [15:0]         period_match_reg,
  input  wire itc_pkg::itc_cnt_wr_s count_wr,
  input  wire logic                cpu_idle,
  input  wire logic                cpu_sleep,
  input  wire logic                ext_count_clock_pin,
  input  wire logic                gate_pin,
  output logic [15:0]              count,
  output logic                     match_irq,
  output logic                     counting
);
  import itc_pkg::*;

  itc_ctrl_s                       ctrl;
  logic [`ITC_PIN_COUNT-1:0]       pin_w;
  logic [`ITC_PIN_COUNT-1:0]       sync1_r;
  logic [`ITC_PIN_COUNT-1:0]       sync2_r;
  logic [`ITC_PIN_COUNT-1:0]       sync3_r;
  logic [`ITC_PIN_COUNT-1:0]       level_r;
  logic [`ITC_PIN_COUNT-1:0]       level_nxt;
  logic [`ITC_PIN_COUNT-1:0]       rise_w;
  logic [`ITC_PIN_COUNT-1:0]       fall_w;
  logic                            gated_w;
  logic                            run_w;
  logic                            src_w;
  logic                            pre_tick_w;
  logic                            tick_w;
  logic                            match_w;
  logic [15:0]                     count_r;
  logic [15:0]                     count_nxt;
  logic                            irq_r;
  logic                            irq_nxt;
  logic                            counting_r;

  // Mode decoding from the control word chosen by software.
  function automatic itc_ctrl_s decode_ctrl(input logic [15:0] word);
    itc_ctrl_s c;
    c.enable    = word[`ITC_CTRL_ON_BIT];
    c.idle_stop = word[`ITC_CTRL_IDLE_STOP_BIT];
    c.gate_en   = word[`ITC_CTRL_GATE_BIT];
    c.prescale  = word[`ITC_CTRL_PS_MSB:`ITC_CTRL_PS_LSB];
    if (!word[`ITC_CTRL_CS_BIT]) begin
      c.mode = ITC_MODE_TIMER;
    end else if (word[`ITC_CTRL_SYNC_BIT]) begin
      c.mode = ITC_MODE_SYNC;
    end else begin
      c.mode = ITC_MODE_ASYNC;
    end
    return c;
  endfunction

  assign ctrl = decode_ctrl(timer_control_reg);

  assign pin_w[`ITC_PIN_EXT]  = ext_count_clock_pin;
  assign pin_w[`ITC_PIN_GATE] = gate_pin;

  // Each pin passes three flops; a change is accepted once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < `ITC_PIN_COUNT; gi++) begin : g_pin
      always_comb begin
        level_nxt[gi] = level_r[gi];
        if (sync2_r[gi] == sync3_r[gi]) begin
          level_nxt[gi] = sync3_r[gi];
        end
      end

      assign rise_w[gi] = level_nxt[gi] & ~level_r[gi];
      assign fall_w[gi] = ~level_nxt[gi] & level_r[gi];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          level_r[gi] <= 1'b0;
        end else if (ce) begin
          sync1_r[gi] <= pin_w[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          level_r[gi] <= level_nxt[gi];
        end
      end
    end
  endgenerate

  assign gated_w = (ctrl.mode == ITC_MODE_TIMER) && ctrl.gate_en;

  // Sleep stops the internally clocked modes; only the asynchronous counter runs on.
  assign run_w = ctrl.enable
                 && !(cpu_idle && ctrl.idle_stop)
                 && !(cpu_sleep && (ctrl.mode != ITC_MODE_ASYNC));

  always_comb begin
    case (ctrl.mode)
      ITC_MODE_TIMER: src_w = gated_w ? level_r[`ITC_PIN_GATE] : 1'b1;
      ITC_MODE_SYNC:  src_w = rise_w[`ITC_PIN_EXT];
      ITC_MODE_ASYNC: src_w = rise_w[`ITC_PIN_EXT];
      default:        src_w = 1'b0;
    endcase
  end

  itc_prescaler #(
    .WIDTH (PS_WIDTH)
  ) u_prescaler (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .clear    (!ctrl.enable),
    .tick_in  (run_w && src_w),
    .sel      (ctrl.prescale),
    .tick_out (pre_tick_w)
  );

  // A tick still in the prescaler is dropped once the gate or the run condition falls.
  assign tick_w  = pre_tick_w && run_w && (!gated_w || level_r[`ITC_PIN_GATE]);
  assign match_w = (count_r == period_match_reg);

  always_comb begin
    count_nxt = count_r;
    if (count_wr.valid) begin
      count_nxt = count_wr.data;
    end else if (tick_w) begin
      if (match_w) begin
        count_nxt = `ITC_COUNT_RST;
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end
    irq_nxt = (tick_w && match_w)
              || (gated_w && ctrl.enable && fall_w[`ITC_PIN_GATE]);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r    <= `ITC_COUNT_RST;
      irq_r      <= 1'b0;
      counting_r <= 1'b0;
    end else if (ce) begin
      count_r    <= count_nxt;
      irq_r      <= irq_nxt;
      counting_r <= run_w;
    end
  end

  assign count     = count_r;
  assign match_irq = irq_r;
  assign counting  = counting_r;

  chk_wrap_zero: assert property (@(posedge clk) disable iff (reset)
    (ce && tick_w && match_w && !count_wr.valid) |=> (count_r == 16'h0000))
    else $error("count did not return to zero on period match");

  chk_step_up: assert property (@(posedge clk) disable iff (reset)
    (ce && tick_w && !match_w && !count_wr.valid) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("count did not advance by one on a tick");

  chk_idle_halt: assert property (@(posedge clk) disable iff (reset)
    (cpu_idle && ctrl.idle_stop && !count_wr.valid) |=> $stable(count_r))
    else $error("count moved during idle with idle stop set");

  chk_sleep_hold: assert property (@(posedge clk) disable iff (reset)
    (cpu_sleep && ctrl.mode != ITC_MODE_ASYNC && !count_wr.valid) |=> $stable(count_r))
    else $error("internally clocked mode counted during sleep");

  chk_match_irq: assert property (@(posedge clk) disable iff (reset)
    (ce && tick_w && match_w) |=> match_irq)
    else $error("no interrupt after period match");

  chk_gate_irq: assert property (@(posedge clk) disable iff (reset)
    (ce && gated_w && ctrl.enable && fall_w[`ITC_PIN_GATE]) |=> match_irq)
    else $error("no interrupt after gate falling edge");

  chk_gate_hold: assert property (@(posedge clk) disable iff (reset)
    (gated_w && !level_r[`ITC_PIN_GATE] && !count_wr.valid) |=> $stable(count_r))
    else $error("gated count moved while gate low");

  chk_ext_only: assert property (@(posedge clk) disable iff (reset)
    (ce && ctrl.mode != ITC_MODE_TIMER && !rise_w[`ITC_PIN_EXT])[*2]
      ##0 (ctrl.prescale == 2'h0) |-> !pre_tick_w)
    else $error("counter mode ticked without an external rising edge");

  chk_write_load: assert property (@(posedge clk) disable iff (reset)
    (ce && count_wr.valid) |=> (count_r == $past(count_wr.data)))
    else $error("count write was not loaded");

endmodule

`default_nettype wire

// *** testbench/itc_ext_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module itc_ext_src (
  input  wire logic clk,
  output logic      ext_count_clock_pin,
  output logic      gate_pin
);
  initial begin
    ext_count_clock_pin = 1'b0;
    gate_pin            = 1'b0;
  end

  // Each level is held four clocks so that the three-flop synchroniser always accepts it.
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk);
      ext_count_clock_pin = 1'b1;
      repeat (4) @(negedge clk);
      ext_count_clock_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  task automatic set_gate(input logic v);
    @(negedge clk);
    gate_pin = v;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_interval_timer_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "itc_defines.svh"
module tb_interval_timer_counter;
  import itc_pkg::*;
  logic        clk, reset, ce, cpu_idle, cpu_sleep, ext_pin, gate_pin, match_irq, counting, got;
  logic [15:0] ctrl, period, count, snap;
  itc_cnt_wr_s wr;
  int          errors, check_count, cycles;

  itc_timer uut (.clk(clk), .reset(reset), .ce(ce), .timer_control_reg(ctrl), .period_match_reg(period),
    .count_wr(wr), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .ext_count_clock_pin(ext_pin),
    .gate_pin(gate_pin), .count(count), .match_irq(match_irq), .counting(counting));
  itc_ext_src src (.clk(clk), .ext_count_clock_pin(ext_pin), .gate_pin(gate_pin));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] mk(input logic [1:0] ps, input logic gt, idl, cs, sy);
    mk = 16'h0000;
    mk[`ITC_CTRL_ON_BIT] = 1'b1;
    mk[`ITC_CTRL_IDLE_STOP_BIT] = idl;
    mk[`ITC_CTRL_GATE_BIT] = gt;
    mk[`ITC_CTRL_PS_MSB:`ITC_CTRL_PS_LSB] = ps;
    mk[`ITC_CTRL_SYNC_BIT] = sy;
    mk[`ITC_CTRL_CS_BIT] = cs;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic setup(input logic [15:0] c, input logic [15:0] p);
    @(negedge clk);
    ctrl = c;
    period = p;
  endtask

  // A write is a one-cycle pulse and shows on the count one cycle later.
  task automatic load(input logic [15:0] d);
    @(negedge clk);
    wr = '{1'b1, d};
    @(negedge clk);
    wr.valid = 1'b0;
    chk("count write", d, count);
  endtask

  task automatic wait_irq(input int n);
    got = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (match_irq === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0; reset = 1'b1; ce = 1'b1; cpu_idle = 1'b0; cpu_sleep = 1'b0;
    ctrl = 16'h0000; period = 16'h0000; wr = '0; errors = 0; check_count = 0; cycles = 0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    chk("reset count", 16'h0000, count);
    setup(mk(2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0003);
    wait_irq(20);
    chk("match irq", 16'h0001, {15'h0, got});
    for (int i = 1; i <= 4; i++) begin
      @(negedge clk);
      chk("wrap count", 16'(i % 4), count);
      chk("wrap irq", {15'h0, i == 4}, {15'h0, match_irq});
    end
    $display("test timer_wrap done");
    setup(mk(2'h1, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0001);
    load(16'h0000);
    wait_irq(40);
    repeat (7) @(negedge clk);
    chk("prescale hold", 16'h0000, count);
    @(negedge clk);
    chk("prescale tick", 16'h0001, count);
    $display("test prescaler done");
    setup(mk(2'h0, 1'b0, 1'b1, 1'b0, 1'b0), 16'hFFFF);
    load(16'h0100);
    cpu_idle = 1'b1;
    repeat (2) @(negedge clk);
    snap = count;
    repeat (10) @(negedge clk);
    chk("idle stop", snap, count);
    ctrl = mk(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    snap = count;
    repeat (10) @(negedge clk);
    chk("idle run", snap + 16'h000A, count);
    cpu_idle = 1'b0;
    $display("test idle done");
    setup(mk(2'h0, 1'b1, 1'b0, 1'b0, 1'b0), 16'hFFFF);
    load(16'h0000);
    repeat (10) @(negedge clk);
    chk("gate low hold", 16'h0000, count);
    src.set_gate(1'b1);
    repeat (10) @(negedge clk);
    chk("gate high run", 16'h0001, {15'h0, count != 16'h0000});
    src.set_gate(1'b0);
    wait_irq(10);
    chk("gate fall irq", 16'h0001, {15'h0, got});
    snap = count;
    repeat (10) @(negedge clk);
    chk("gate fall hold", snap, count);
    $display("test gate done");
    setup(mk(2'h0, 1'b0, 1'b1, 1'b1, 1'b1), 16'h0002);
    load(16'h0000);
    src.pulses(5);
    repeat (6) @(negedge clk);
    chk("sync count", 16'h0002, count);
    cpu_idle = 1'b1;
    src.pulses(3);
    repeat (6) @(negedge clk);
    chk("sync idle", 16'h0002, count);
    cpu_idle = 1'b0;
    $display("test sync_counter done");
    setup(mk(2'h0, 1'b0, 1'b1, 1'b1, 1'b0), 16'h0002);
    load(16'h0000);
    cpu_sleep = 1'b1;
    src.pulses(5);
    repeat (6) @(negedge clk);
    chk("async sleep count", 16'h0002, count);
    cpu_sleep = 1'b0;
    cpu_idle = 1'b1;
    src.pulses(3);
    repeat (6) @(negedge clk);
    chk("async idle", 16'h0002, count);
    cpu_idle = 1'b0;
    $display("test async_counter done");
    // A running 1:1 timer must freeze with the clock enable low and hold in sleep.
    setup(mk(2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 16'hFFFF);
    load(16'h0000);
    ce = 1'b0;
    repeat (6) @(negedge clk);
    chk("ce freeze", 16'h0000, count);
    ce = 1'b1;
    cpu_sleep = 1'b1;
    repeat (2) @(negedge clk);
    snap = count;
    chk("sleep counting", 16'h0000, {15'h0, counting});
    repeat (5) @(negedge clk);
    chk("sleep hold", snap, count);
    cpu_sleep = 1'b0;
    repeat (3) @(negedge clk);
    chk("sleep resume", snap + 16'h0002, count);
    chk("resume counting", 16'h0001, {15'h0, counting});
    $display("test ce_sleep done");
    // Disabling first clears the prescaler so the first long-ratio tick lands at a known cycle.
    for (int k = 2; k < 4; k++) begin
      setup(16'h0000, 16'hFFFF);
      load(16'h0000);
      ctrl = mk(2'(k), 1'b0, 1'b0, 1'b0, 1'b0);
      repeat ((k == 2) ? 64 : 256) @(negedge clk);
      chk("prescale long hold", 16'h0000, count);
      @(negedge clk);
      chk("prescale long tick", 16'h0001, count);
    end
    $display("test prescaler_long done");
    finish_test();
  end
endmodule
`default_nettype wire
